// [design/transmit_test_pattern_gen.sv]
// transmit test pattern generator with an axi4-lite register slave
// Notes on behaviour
// - carrier mode forces static values onto the transmit i/q dac inputs.
// - mode 3 plus transmit-on sends crc pseudo-random bytes, not buffer data.
// - each byte is crc low byte; crc then advanced with byte 0xff.
// - pseudo-random data repeats with a period of 32767 bytes.
// - payload after header begins 00 78 b8 4b 99 c3 e9.
// - every transmit mode sends preamble and start delimiter before data.
// - mode 2 repeats buffer contents, ignoring buffer underflow.
// - repeated sequence is the full buffer: 128 bytes, 1024 bits.
module transmit_test_pattern_gen #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    // oscillator status pin
    input  wire logic              i_osc_stable,
    // axi4-lite write address and data
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    // axi4-lite write response
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    output logic [1:0]             o_bresp,
    // axi4-lite read
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    // byte stream to the modulator
    output logic                   o_tx_valid,
    input  wire logic              i_tx_ready,
    output logic [7:0]             o_tx_data,
    // dac override and status
    output logic                   o_dac_override,
    output logic [15:0]            o_dac_value,
    output logic                   o_tx_active
);

    logic [1:0]           rst_sync_r;
    logic                 rst_n;
    tx_test_pkg::state_s  q_r;
    tx_test_pkg::state_s  q_nxt;
    logic                 gen_valid;
    logic [7:0]           gen_data;
    logic                 in_ready;
    logic                 push;
    logic                 pop;

    // reset released through two flops
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_comb begin
        q_nxt     = q_r;
        gen_valid = 1'b0;
        gen_data  = tx_test_pkg::PREAMBLE;
        q_nxt.osc_sync = {q_r.osc_sync[0], i_osc_stable};

        // byte source; payload kind fixed by the mode latched at start
        unique case (q_r.st)
            tx_test_pkg::ST_IDLE: begin
            end
            tx_test_pkg::ST_HDR: begin
                gen_valid = 1'b1;
                if (q_r.hdr_cnt < tx_test_pkg::PREAMBLE_LEN) begin
                    gen_data = tx_test_pkg::PREAMBLE;
                end else begin
                    gen_data = tx_test_pkg::SFD_BYTE;
                end
            end
            tx_test_pkg::ST_DATA: begin
                if (q_r.run_mode == tx_test_pkg::MODE_PRBS) begin
                    gen_valid = 1'b1;
                    gen_data  = q_r.crc[7:0];
                end else if (q_r.run_mode == tx_test_pkg::MODE_CARRIER) begin
                    gen_valid = 1'b1;
                    gen_data  = q_r.mem[q_r.rd_idx];
                end else begin
                    gen_valid = ({1'b0, q_r.rd_idx} < q_r.fill);
                    gen_data  = q_r.mem[q_r.rd_idx];
                end
            end
        endcase

        // two-entry buffer: ready only while the tail is free
        in_ready = !q_r.tail.valid;
        push     = gen_valid && in_ready;
        pop      = q_r.head.valid && i_tx_ready;
        if (pop) begin
            if (q_r.tail.valid) begin
                q_nxt.head       = q_r.tail;
                q_nxt.tail.valid = 1'b0;
            end else begin
                q_nxt.head.valid = push;
                q_nxt.head.data  = gen_data;
            end
            if (q_r.tail.valid && push) begin
                q_nxt.tail.valid = 1'b1;
                q_nxt.tail.data  = gen_data;
            end
        end else if (push) begin
            if (q_r.head.valid) begin
                q_nxt.tail.valid = 1'b1;
                q_nxt.tail.data  = gen_data;
            end else begin
                q_nxt.head.valid = 1'b1;
                q_nxt.head.data  = gen_data;
            end
        end

        // advance the source on each accepted byte
        if (push) begin
            unique case (q_r.st)
                tx_test_pkg::ST_IDLE: begin
                end
                tx_test_pkg::ST_HDR: begin
                    if (q_r.hdr_cnt == tx_test_pkg::HDR_LAST) begin
                        q_nxt.st = tx_test_pkg::ST_DATA;
                    end else begin
                        q_nxt.hdr_cnt = 3'(q_r.hdr_cnt + 3'h1);
                    end
                end
                tx_test_pkg::ST_DATA: begin
                    // polynomial stepping gives the long period
                    q_nxt.crc = tx_test_pkg::crc_step(q_r.crc,
                        tx_test_pkg::PRBS_FEED);
                    // index wraps at the buffer size, underflow ignored
                    q_nxt.rd_idx = q_r.rd_idx + 7'h1;
                    // a single pass ends on the last filled byte, even when
                    // the buffer is full and the index would wrap
                    if (q_r.run_mode != tx_test_pkg::MODE_PRBS &&
                        q_r.run_mode != tx_test_pkg::MODE_CARRIER &&
                        {1'b0, q_r.rd_idx} == 8'(q_r.fill - 8'h1)) begin
                        q_nxt.st = tx_test_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        if (q_r.st == tx_test_pkg::ST_DATA && !gen_valid) begin
            q_nxt.st = tx_test_pkg::ST_IDLE;
        end

        // axi write channels taken in either order
        if (i_awvalid && q_r.awready) begin
            q_nxt.aw_got  = 1'b1;
            q_nxt.aw_addr = 8'(i_awaddr);
        end
        if (i_wvalid && q_r.wready) begin
            q_nxt.w_got  = 1'b1;
            q_nxt.w_data = i_wdata;
            q_nxt.w_strb = i_wstrb;
        end
        if (q_r.bvalid && i_bready) begin
            q_nxt.bvalid = 1'b0;
        end
        if (q_r.aw_got && q_r.w_got && !q_r.bvalid) begin
            q_nxt.aw_got = 1'b0;
            q_nxt.w_got  = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp  = tx_test_pkg::RESP_OKAY;
            unique case (q_r.aw_addr)
                tx_test_pkg::OFS_CTRL: begin
                    if (q_r.w_strb[0]) begin
                        q_nxt.mode = q_r.w_data[1:0];
                    end
                end
                tx_test_pkg::OFS_DAC: begin
                    if (q_r.w_strb[0]) begin
                        q_nxt.dac[7:0] = q_r.w_data[7:0];
                    end
                    if (q_r.w_strb[1]) begin
                        q_nxt.dac[15:8] = q_r.w_data[15:8];
                    end
                end
                tx_test_pkg::OFS_CMD: begin
                    if (q_r.w_strb[0]) begin
                        // start only from idle with the oscillator settled
                        if (q_r.w_data[tx_test_pkg::CMD_TXON_BIT] &&
                            q_r.osc_sync[1] &&
                            q_r.st == tx_test_pkg::ST_IDLE) begin
                            q_nxt.st       = tx_test_pkg::ST_HDR;
                            q_nxt.hdr_cnt  = 3'h0;
                            q_nxt.rd_idx   = '0;
                            q_nxt.crc      = tx_test_pkg::CRC_SEED;
                            q_nxt.run_mode = q_r.mode;
                        end
                        if (q_r.w_data[tx_test_pkg::CMD_STOP_BIT]) begin
                            q_nxt.st = tx_test_pkg::ST_IDLE;
                        end
                        if (q_r.w_data[tx_test_pkg::CMD_FLUSH_BIT]) begin
                            q_nxt.fill = 8'h00;
                        end
                    end
                end
                tx_test_pkg::OFS_BUF: begin
                    // writes past a full buffer are dropped
                    if (q_r.w_strb[0] && q_r.fill < tx_test_pkg::BUF_FULL) begin
                        q_nxt.mem[q_r.fill[tx_test_pkg::IDX_W-1:0]] =
                            q_r.w_data[7:0];
                        q_nxt.fill = 8'(q_r.fill + 8'h1);
                    end
                end
                tx_test_pkg::OFS_STAT: begin
                end
                default: begin
                    q_nxt.bresp = tx_test_pkg::RESP_SLVERR;
                end
            endcase
        end

        // axi read
        if (q_r.rvalid && i_rready) begin
            q_nxt.rvalid = 1'b0;
        end
        if (i_arvalid && q_r.arready) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp  = tx_test_pkg::RESP_OKAY;
            q_nxt.rdata  = 32'h0;
            unique case (8'(i_araddr))
                tx_test_pkg::OFS_CTRL: q_nxt.rdata[1:0]  = q_r.mode;
                tx_test_pkg::OFS_DAC:  q_nxt.rdata[15:0] = q_r.dac;
                tx_test_pkg::OFS_CMD:  q_nxt.rdata       = 32'h0;
                tx_test_pkg::OFS_BUF:  q_nxt.rdata       = 32'h0;
                tx_test_pkg::OFS_STAT: begin
                    q_nxt.rdata[tx_test_pkg::STAT_ACT_BIT] =
                        (q_r.st != tx_test_pkg::ST_IDLE);
                    q_nxt.rdata[tx_test_pkg::STAT_OSC_BIT] = q_r.osc_sync[1];
                    q_nxt.rdata[tx_test_pkg::STAT_FILL_LSB +: 8] = q_r.fill;
                    q_nxt.rdata[tx_test_pkg::STAT_CRC_LSB +: 16] = q_r.crc;
                end
                default: q_nxt.rresp = tx_test_pkg::RESP_SLVERR;
            endcase
        end

        // registered ready and override outputs
        q_nxt.awready = !q_nxt.aw_got && !q_nxt.bvalid;
        q_nxt.wready  = !q_nxt.w_got && !q_nxt.bvalid;
        q_nxt.arready = !q_nxt.rvalid;
        q_nxt.dac_ovr = (q_nxt.st != tx_test_pkg::ST_IDLE) &&
            (q_nxt.run_mode == tx_test_pkg::MODE_CARRIER);
        q_nxt.active  = (q_nxt.st != tx_test_pkg::ST_IDLE);
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_r          <= '0;
            q_r.st       <= tx_test_pkg::ST_IDLE;
            q_r.mode     <= tx_test_pkg::MODE_RST;
            q_r.run_mode <= tx_test_pkg::MODE_RST;
            q_r.dac      <= tx_test_pkg::DAC_RST;
            q_r.crc      <= tx_test_pkg::CRC_SEED;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_awready      = q_r.awready;
    assign o_wready       = q_r.wready;
    assign o_bvalid       = q_r.bvalid;
    assign o_bresp        = q_r.bresp;
    assign o_arready      = q_r.arready;
    assign o_rvalid       = q_r.rvalid;
    assign o_rdata        = q_r.rdata;
    assign o_rresp        = q_r.rresp;
    assign o_tx_valid     = q_r.head.valid;
    assign o_tx_data      = q_r.head.data;
    assign o_dac_override = q_r.dac_ovr;
    assign o_dac_value    = q_r.dac;
    assign o_tx_active    = q_r.active;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_hdr_end;
        q_r.st == tx_test_pkg::ST_HDR && push &&
            q_r.hdr_cnt == tx_test_pkg::HDR_LAST;
    endsequence
    sequence s_prbs_push;
        q_r.st == tx_test_pkg::ST_DATA && push &&
            q_r.run_mode == tx_test_pkg::MODE_PRBS;
    endsequence

    a_carrier_dac_held: assert property (
        q_r.st != tx_test_pkg::ST_IDLE &&
            q_r.run_mode == tx_test_pkg::MODE_CARRIER
            |-> o_dac_override && o_dac_value == q_r.dac)
        else $error("carrier mode without dac override");
    a_prbs_byte_src: assert property (
        s_prbs_push |-> gen_data == q_r.crc[7:0])
        else $error("pseudo-random byte not crc low byte");
    a_prbs_crc_moves: assert property (
        s_prbs_push |=> q_r.crc ==
            tx_test_pkg::crc_step($past(q_r.crc), tx_test_pkg::PRBS_FEED))
        else $error("crc not advanced with 0xff");
    a_prbs_no_stall: assert property (
        s_prbs_push |=> q_r.crc != $past(q_r.crc))
        else $error("pseudo-random sequence stuck");
    a_prbs_seq_start: assert property (
        s_hdr_end ##1 (q_r.run_mode == tx_test_pkg::MODE_PRBS)
            |-> q_r.crc == 16'h0000)
        else $error("pseudo-random payload not starting at 0x00");
    a_crc_poly_step: assert property (
        s_prbs_push and (q_r.crc == 16'h0000)
            |=> q_r.crc == 16'h0f78 ##0 gen_data == 8'h78 || !push)
        else $error("crc polynomial step wrong");
    a_header_sfd_last: assert property (
        s_hdr_end |-> gen_data == tx_test_pkg::SFD_BYTE
            ##1 q_r.st == tx_test_pkg::ST_DATA)
        else $error("header not ended by delimiter");
    a_header_first: assert property (
        $rose(o_tx_active) |-> q_r.st == tx_test_pkg::ST_HDR &&
            q_r.hdr_cnt == 3'h0)
        else $error("transmission not starting with header");
    a_repeat_wraps: assert property (
        q_r.st == tx_test_pkg::ST_DATA && push &&
            q_r.run_mode == tx_test_pkg::MODE_CARRIER &&
            q_r.rd_idx == 7'h7f
            |=> q_r.rd_idx == 7'h00 && q_r.st == tx_test_pkg::ST_DATA)
        else $error("buffer repeat not wrapping at 128 bytes");
    a_buffer_no_loss: assert property (
        q_r.tail.valid && !i_tx_ready |=> q_r.tail.valid &&
            $stable(q_r.tail.data) && $stable(q_r.head.data))
        else $error("stalled buffer lost a byte");
    a_single_pass_end: assert property (
        q_r.st == tx_test_pkg::ST_DATA && push &&
            q_r.run_mode != tx_test_pkg::MODE_PRBS &&
            q_r.run_mode != tx_test_pkg::MODE_CARRIER &&
            {1'b0, q_r.rd_idx} == 8'(q_r.fill - 8'h1)
            |=> !o_tx_active)
        else $error("single pass not ending at the buffer fill");

endmodule // transmit_test_pattern_gen

// [inc/tx_test_pkg.sv]
// constants, types and the pattern step function for the test pattern generator
package tx_test_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DAC  = 8'h04;
    localparam logic [7:0] OFS_CMD  = 8'h08;
    localparam logic [7:0] OFS_BUF  = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // command and status bit positions
    localparam int unsigned CMD_TXON_BIT  = 0;
    localparam int unsigned CMD_STOP_BIT  = 1;
    localparam int unsigned CMD_FLUSH_BIT = 2;
    localparam int unsigned STAT_ACT_BIT  = 0;
    localparam int unsigned STAT_OSC_BIT  = 1;
    localparam int unsigned STAT_FILL_LSB = 8;
    localparam int unsigned STAT_CRC_LSB  = 16;

    // test mode codes
    localparam logic [1:0] MODE_CARRIER = 2'h2;
    localparam logic [1:0] MODE_PRBS    = 2'h3;

    // reset values and pattern constants
    localparam logic [1:0]  MODE_RST     = 2'h0;
    localparam logic [15:0] DAC_RST      = 16'h0000;
    localparam logic [15:0] CRC_SEED     = 16'h0000;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [7:0]  PRBS_FEED    = 8'hff;
    localparam logic [7:0]  PREAMBLE     = 8'h00;
    localparam logic [7:0]  SFD_BYTE     = 8'ha7;
    localparam logic [2:0]  PREAMBLE_LEN = 3'h4;
    localparam logic [2:0]  HDR_LAST     = 3'h4;

    // transmit buffer geometry
    localparam int unsigned BUF_BYTES = 128;
    localparam int unsigned IDX_W     = 7;
    localparam logic [7:0]  BUF_FULL  = 8'h80;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HDR  = 3'h2,
        ST_DATA = 3'h4
    } tx_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } entry_s;

    typedef struct packed {
        tx_state_e                  st;
        logic [1:0]                 mode;
        logic [1:0]                 run_mode;
        logic [15:0]                dac;
        logic                       dac_ovr;
        logic                       active;
        logic [15:0]                crc;
        logic [2:0]                 hdr_cnt;
        logic [IDX_W-1:0]           rd_idx;
        logic [7:0]                 fill;
        logic [BUF_BYTES-1:0][7:0]  mem;
        entry_s                     head;
        entry_s                     tail;
        logic [1:0]                 osc_sync;
        logic                       aw_got;
        logic [7:0]                 aw_addr;
        logic                       w_got;
        logic [31:0]                w_data;
        logic [3:0]                 w_strb;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } state_s;

    // one byte through the bitwise reflected crc
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r  = {1'b0, r[15:1]};
            if (fb) begin
                r = r ^ CRC_POLY_REV;
            end
        end
        return r;
    endfunction

endpackage

// [verification/tx_stream_sink.sv]
// stream sink standing in for the modulator, stalling to a bench pattern
module tx_stream_sink (
    // clock
    input  wire logic       i_clk,
    // stall pattern, a one holds ready low for that cycle
    input  wire logic [7:0] i_stall_pat,
    // stream handshake
    output logic            o_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] idx_r = 3'h0;

    initial o_ready = 1'b0;

    // ready moves only just after an edge, so a byte is never half taken
    always @(posedge i_clk) begin
        o_ready <= ~i_stall_pat[idx_r];
        idx_r   <= idx_r + 3'h1;
    end
endmodule // tx_stream_sink

// [verification/test_transmit_test_pattern_gen.sv]
// self-checking bench for the transmit test pattern generator
module test_transmit_test_pattern_gen;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, reset_n, osc_stable;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, tx_data, stall_pat;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        tx_valid, tx_ready, dac_ovr, tx_active;
    logic [15:0] dac_val;
    logic [7:0]  rxq [$];
    logic [7:0]  bufd [128];
    integer      seed;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    transmit_test_pattern_gen u_transmit_test_pattern_gen (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_osc_stable(osc_stable),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .o_tx_data(tx_data),
        .o_dac_override(dac_ovr), .o_dac_value(dac_val),
        .o_tx_active(tx_active));

    tx_stream_sink u_tx_stream_sink (
        .i_clk(clk_sys), .i_stall_pat(stall_pat), .o_ready(tx_ready));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // every byte taken by the sink, in order
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) rxq.push_back(tx_data);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        int n;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        @(posedge clk_sys);
        chk(32'(n < 100), 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge clk_sys);
        chk(32'(n < 100), 32'h1);
    endtask

    // next pattern word: one byte of ones through the reflected crc
    function automatic logic [15:0] prbs_next(input logic [15:0] c);
        logic [15:0] v;
        v = c;
        for (int k = 0; k < 8; k++) begin
            v = (v[0] ^ 1'b1) ? ((v >> 1) ^ 16'h8408) : (v >> 1);
        end
        return v;
    endfunction

    task automatic wait_bytes(input int cnt);
        for (int k = 0; k < 5000 && rxq.size() < cnt; k++) @(posedge clk_sys);
        chk(32'(rxq.size() >= cnt), 32'h1);
    endtask

    task automatic header;
        for (int k = 0; k < 4; k++) chk(rxq[k], tx_test_pkg::PREAMBLE);
        chk(rxq[4], tx_test_pkg::SFD_BYTE);
    endtask

    task automatic stop_run;
        logic [1:0] r;
        wr(tx_test_pkg::OFS_CMD, 32'h1 << tx_test_pkg::CMD_STOP_BIT, 4'h1, r);
        for (int k = 0; k < 200 && tx_active !== 1'b0; k++) @(posedge clk_sys);
        chk(tx_active, 1'b0);
        chk(dac_ovr, 1'b0);
        // drain the two-entry buffer fully so no stale byte leads the next run
        for (int k = 0; k < 200 && tx_valid !== 1'b0; k++) @(posedge clk_sys);
        chk(tx_valid, 1'b0);
        rxq.delete();
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] c;
        logic [7:0]  ref7 [7];
        ref7 = '{8'h00, 8'h78, 8'hb8, 8'h4b, 8'h99, 8'hc3, 8'he9};
        seed = 32'h43a74bcb;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        reset_n = 1'b0;
        osc_stable = 1'b0;
        stall_pat = 8'h00;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // reset values; command and buffer places read back zero
        for (int k = 0; k < 5; k++) begin
            rd(8'(4 * k), d, r);
            chk(d, 32'h0);
            chk(r, tx_test_pkg::RESP_OKAY);
        end
        rd(8'h14, d, r);
        chk(r, tx_test_pkg::RESP_SLVERR);
        wr(8'h14, 32'hffffffff, 4'hf, r);
        chk(r, tx_test_pkg::RESP_SLVERR);
        wr(tx_test_pkg::OFS_STAT, 32'hffffffff, 4'hf, r);
        chk(r, tx_test_pkg::RESP_OKAY);
        // start without a settled oscillator must stay idle
        wr(tx_test_pkg::OFS_CMD, 32'h1, 4'h1, r);
        repeat (4) @(posedge clk_sys);
        chk(tx_active, 1'b0);
        chk(32'(rxq.size()), 32'h0);
        osc_stable <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // fill past full: the extra byte is dropped
        for (int k = 0; k < 129; k++) begin
            d = $random(seed);
            if (k < 128) bufd[k] = d[7:0];
            wr(tx_test_pkg::OFS_BUF, {24'h0, d[7:0]}, 4'h1, r);
        end
        rd(tx_test_pkg::OFS_STAT, d, r);
        chk(d[15:8], tx_test_pkg::BUF_FULL);
        chk(d[1], 1'b1);
        wr(tx_test_pkg::OFS_DAC, 32'h1800, 4'h3, r);
        wr(tx_test_pkg::OFS_CTRL, 32'h2, 4'h1, r);
        rd(tx_test_pkg::OFS_DAC, d, r);
        chk(d, 32'h1800);
        rd(tx_test_pkg::OFS_CTRL, d, r);
        chk(d, 32'h2);
        stall_pat <= 8'($random(seed)) & 8'h7f;
        rxq.delete();
        wr(tx_test_pkg::OFS_CMD, 32'h1, 4'h1, r);
        repeat (2) @(posedge clk_sys);
        chk(dac_ovr, 1'b1);
        chk(dac_val, 16'h1800);
        chk(tx_active, 1'b1);
        wait_bytes(5 + 256);
        header();
        for (int k = 0; k < 256; k++) chk(rxq[5 + k], bufd[k % 128]);
        stop_run();
        // pseudo-random run under heavy stalls
        wr(tx_test_pkg::OFS_CTRL, 32'h3, 4'h1, r);
        stall_pat <= 8'h6d;
        wr(tx_test_pkg::OFS_CMD, 32'h1, 4'h1, r);
        repeat (2) @(posedge clk_sys);
        chk(dac_ovr, 1'b0);
        wait_bytes(5 + 48);
        header();
        c = 16'h0000;
        for (int k = 0; k < 48; k++) begin
            chk(rxq[5 + k], c[7:0]);
            c = prbs_next(c);
        end
        for (int k = 0; k < 7; k++) chk(rxq[5 + k], ref7[k]);
        stop_run();
        // plain mode on a full buffer: one pass of 128 bytes, then idle
        wr(tx_test_pkg::OFS_CTRL, 32'h0, 4'h1, r);
        wr(tx_test_pkg::OFS_CMD, 32'h1, 4'h1, r);
        wait_bytes(5 + 128);
        header();
        for (int k = 0; k < 128; k++) chk(rxq[5 + k], bufd[k]);
        for (int k = 0; k < 200 && tx_active !== 1'b0; k++) @(posedge clk_sys);
        chk(tx_active, 1'b0);
        chk(dac_ovr, 1'b0);
        repeat (40) @(posedge clk_sys);
        chk(32'(rxq.size()), 32'h85);
        results();
    end

    // hang guard: far beyond the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end
endmodule // test_transmit_test_pattern_gen
